// *** common/sdm_link_pkg.sv ***
// Shared constants for the bitstream modulator model and the sinc3 decimator.
// Assumes both ends compile against this package before their own files.
package sdm_link_pkg;
  // ----------------------------------------
  // Stream coding
  // ----------------------------------------
  localparam int unsigned DENS_W = 16;             // Ones-density code width
  localparam logic [15:0] DENS_MID = 16'h8000;     // Zero input, half ones
  localparam logic [15:0] DENS_RESET = 16'h8000;   // Density after reset
  localparam logic [16:0] ACC_RESET = 17'h00000;   // Modulator accumulator reset
  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  localparam int unsigned SYS_CLK_MHZ = 25;        // System clock rate
  localparam int unsigned MOD_CLK_MHZ = 10;        // Nominal bit rate
  localparam int unsigned MCLK_HALF = (SYS_CLK_MHZ + 2 * MOD_CLK_MHZ - 1) / (2 * MOD_CLK_MHZ);
  localparam logic [3:0] MCLK_HALF_CYC = MCLK_HALF[3:0]; // Half period in sys cycles
  // ----------------------------------------
  // Decimation filter
  // ----------------------------------------
  localparam int unsigned DEC_RATIO = 256;         // Bits per output word
  localparam int unsigned DEC_LOG2 = 8;            // log2 of ratio
  localparam int unsigned WORD_W = 16;             // Output word width
  localparam int unsigned ACC_W = 3 * DEC_LOG2 + 1; // 25-bit register growth
  localparam logic [7:0] DEC_CNT_RESET = 8'h00;    // Decimation counter reset
  localparam logic [1:0] SETTLE_WORDS = 2'h3;      // Words dropped after reset
  localparam logic [15:0] WORD_MAX = 16'hffff;     // Positive full scale code
endpackage : sdm_link_pkg

// *** common/sdm_link_if.sv ***
// Single-bit modulator link: clock and data from modulator to filter.
// Assumes the testbench instantiates it and connects both ends.
`timescale 1ns/10ps
`default_nettype none
interface sdm_link_if;
  logic mclk; // Modulator clock, made by the modulator end
  logic mdat; // Data bit, changes with each rising mclk
  modport modulator (output mclk, output mdat);
  modport filter (input mclk, input mdat);
endinterface : sdm_link_if
`default_nettype wire

// *** design/sinc3_decimator.sv ***
// Sinc3 decimating filter that turns the single-bit stream into 16-bit words.
// Assumes mclk arrives free-running from the modulator end; words leave on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module sinc3_decimator
  import sdm_link_pkg::*;
(
  // System side
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Link
  sdm_link_if.filter link,
  // Filter controls
  input wire logic sync_clr,
  input wire logic [15:0] offset_trim,
  input wire logic [15:0] gain_trim,
  input wire logic [15:0] ovl_limit,
  // Word output
  output logic [15:0] word_data,
  output logic word_valid,
  output logic overload
);
  // ----------------------------------------
  // Link domain: integrators at the bit rate
  // ----------------------------------------
  logic [ACC_W-1:0] int_q [3]; // Integrator chain
  logic [ACC_W-1:0] snap_q; // Last integrator snapshot
  logic [7:0] dcnt_q; // Decimation counter
  logic snap_tog_q; // Toggles on each snapshot
  logic lrst_m_q, lrst_q; // Clear synchronised into link clock
  logic len_m_q, len_q; // Clock enable synchronised into link clock
  logic clr_req_q; // Clear level on sys side
  wire logic lrst = lrst_q;
  wire logic bit_one = link.mdat;

  // Sync clear request is held as a level for the link domain
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      clr_req_q <= 1'b1;
    else if (clk_en)
      clr_req_q <= sync_clr;
  end

  // Two-stage crossing of clear and enable
  always_ff @(posedge link.mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lrst_m_q <= 1'b1;
      lrst_q <= 1'b1;
      len_m_q <= 1'b0;
      len_q <= 1'b0;
    end
    else
    begin
      lrst_m_q <= clr_req_q;
      lrst_q <= lrst_m_q;
      len_m_q <= clk_en;
      len_q <= len_m_q;
    end
  end

  // Integrators take one bit per rising mclk; wraparound is harmless in a CIC
  always_ff @(posedge link.mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_q[0] <= '0;
      int_q[1] <= '0;
      int_q[2] <= '0;
      dcnt_q <= DEC_CNT_RESET;
      snap_q <= '0;
      snap_tog_q <= 1'b0;
    end
    else if (lrst)
    begin
      int_q[0] <= '0;
      int_q[1] <= '0;
      int_q[2] <= '0;
      dcnt_q <= DEC_CNT_RESET;
    end
    else if (len_q)
    begin
      int_q[0] <= int_q[0] + {{(ACC_W-1){1'b0}}, bit_one};
      int_q[1] <= int_q[1] + int_q[0];
      int_q[2] <= int_q[2] + int_q[1];
      dcnt_q <= dcnt_q + 8'h01;
      if (dcnt_q == 8'hff)
      begin
        // Snapshot every 256 bits, then flag it across the boundary
        snap_q <= int_q[2];
        snap_tog_q <= ~snap_tog_q;
      end
    end
  end

  // ----------------------------------------
  // System domain: combs at the word rate
  // ----------------------------------------
  logic tog_m_q, tog_s_q, tog_p_q; // Toggle synchroniser and edge memory
  logic [ACC_W-1:0] cap_q; // Snapshot held stable in sys domain
  logic cap_v_q; // Capture done, combs next cycle
  logic [ACC_W-1:0] d1_q, d2_q, d3_q; // Comb delays
  logic [1:0] settle_q; // Words still to drop
  wire logic new_word = tog_s_q ^ tog_p_q;

  // Snapshot is stable for 256 bit times, so it is safe to take once the toggle lands
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tog_m_q <= 1'b0;
      tog_s_q <= 1'b0;
      tog_p_q <= 1'b0;
      cap_q <= '0;
      cap_v_q <= 1'b0;
    end
    else if (clk_en)
    begin
      tog_m_q <= snap_tog_q;
      tog_s_q <= tog_m_q;
      tog_p_q <= tog_s_q;
      cap_v_q <= new_word;
      if (new_word)
        cap_q <= snap_q;
    end
  end

  // Three comb stages and correction
  wire logic [ACC_W-1:0] c1 = cap_q - d1_q;
  wire logic [ACC_W-1:0] c2 = c1 - d2_q;
  wire logic [ACC_W-1:0] c3 = c2 - d3_q;
  // Full scale 2^24 saturates to the top code
  wire logic [15:0] raw = c3[ACC_W-1] ? WORD_MAX : c3[23:8];
  // Two spare bits so a trim below mid-scale cannot wrap a high word to zero
  wire logic [17:0] offs = {2'b00, raw} + {2'b00, DENS_MID} - {2'b00, offset_trim};
  // Below zero clamps to the bottom code, past 16 bits to the top code
  wire logic [15:0] offc = offs[17] ? 16'h0000 : (offs[16] ? WORD_MAX : offs[15:0]);
  wire logic [31:0] prod = offc * gain_trim; // Gain in 1.15 format
  wire logic [16:0] scl = prod[31:15];
  wire logic [15:0] fin = scl[16] ? WORD_MAX : scl[15:0];
  wire logic ovl = (fin > ovl_limit) || (fin < (WORD_MAX - ovl_limit));

  // Comb update, settle count and output register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      d1_q <= '0;
      d2_q <= '0;
      d3_q <= '0;
      settle_q <= SETTLE_WORDS;
      word_data <= DENS_MID;
      word_valid <= 1'b0;
      overload <= 1'b0;
    end
    else if (clk_en)
    begin
      word_valid <= 1'b0;
      if (sync_clr)
      begin
        d1_q <= '0;
        d2_q <= '0;
        d3_q <= '0;
        settle_q <= SETTLE_WORDS;
      end
      else if (cap_v_q)
      begin
        d1_q <= cap_q;
        d2_q <= c1;
        d3_q <= c2;
        if (settle_q != 2'h0)
          settle_q <= settle_q - 2'h1;
        else
        begin
          word_data <= fin;
          word_valid <= 1'b1;
          overload <= ovl;
        end
      end
    end
  end
endmodule : sinc3_decimator
`default_nettype wire

// *** design/sdm_modulator.sv ***
// Behavioural-digital model of the modulator end: first-order ones-density coder.
// Assumes input level arrives as a 16-bit offset-binary density on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module sdm_modulator
  import sdm_link_pkg::*;
(
  // System side
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Input level: code = vin/640mV*65536 + 32768, saturated outside +/-320 mV
  input wire logic [15:0] vin_code,
  // Link
  sdm_link_if.modulator link
);
  // ----------------------------------------
  // Clock divider: the modulator makes mclk
  // ----------------------------------------
  logic [3:0] div_q; // Half period counter
  logic mclk_q; // Link clock out
  logic mdat_q; // Data bit out
  logic [16:0] acc_q; // Density accumulator
  logic [15:0] dens_q; // Sampled level
  wire logic half_done = (div_q == MCLK_HALF_CYC - 4'h1);
  wire logic rise = half_done && !mclk_q;
  wire logic [16:0] sum = {1'b0, acc_q[15:0]} + {1'b0, dens_q};
  // 0xffff is taken as full scale so +320 mV and up yields all ones
  wire logic full_one = (dens_q == WORD_MAX);

  // Divider toggles mclk every half period (6.25 MHz at 25 MHz sys clock)
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= 4'h0;
      mclk_q <= 1'b0;
    end
    else if (clk_en)
    begin
      div_q <= half_done ? 4'h0 : div_q + 4'h1;
      if (half_done)
        mclk_q <= ~mclk_q;
    end
  end

  // One bit per mclk period, changed with the rising edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= ACC_RESET;
      mdat_q <= 1'b0;
      dens_q <= DENS_RESET;
    end
    else if (clk_en && rise)
    begin
      dens_q <= vin_code;
      acc_q <= {1'b0, sum[15:0]};
      // Carry out gives ones at density code/65536; mid-scale gives half
      mdat_q <= sum[16] | full_one;
    end
  end

  assign link.mclk = mclk_q;
  assign link.mdat = mdat_q;
endmodule : sdm_modulator
`default_nettype wire

// *** testbench/sdm_link_sva.sv ***
// Link checker: clock shape and data timing on the modulator link.
// Assumes the link clock is a register of the sys_clk domain.
`timescale 1ns/10ps
`default_nettype none
module sdm_link_sva
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link wires
  input wire logic mclk,
  input wire logic mdat
);
  // -------------------------------
  // Link properties
  // -------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_mclk_high_hold: assert property ($rose(mclk) |-> mclk[*2] ##1 !mclk)
    else $error("link clock high phase wrong");
  a_mclk_low_hold: assert property ($fell(mclk) |-> !mclk[*2] ##1 mclk)
    else $error("link clock low phase wrong");
  a_mclk_period: assert property ($rose(mclk) |-> ##4 $rose(mclk))
    else $error("link clock period wrong");
  a_high_ends: assert property (mclk |-> ##[1:2] !mclk)
    else $error("link clock stuck high");
  a_low_ends: assert property (!mclk |-> ##[1:4] mclk)
    else $error("link clock stuck low");
  a_data_at_rise: assert property ($changed(mdat) |-> $rose(mclk))
    else $error("data changed away from clock rise");
  a_data_stands: assert property ($rose(mclk) |=> $stable(mdat)[*3])
    else $error("data bit did not stand one period");
  a_fall_stable: assert property ($fell(mclk) |-> $stable(mdat))
    else $error("data moved at clock fall");
  // Main stream shapes seen
  cover property ($rose(mdat));
  cover property ($fell(mdat));
  cover property (mdat[*8]);
endmodule // sdm_link_sva
`default_nettype wire

// *** testbench/test_bitstream_sinc3_decimator.sv ***
// Bench: modulator and decimator joined by the link, DC levels end to end.
// Assumes the modulator makes the link clock; the bench drives levels, trims, clear and reset.
`timescale 1ns/10ps
`default_nettype none
module test_bitstream_sinc3_decimator;
  import sdm_link_pkg::*;
  // -------------------------------
  // Stimulus and results
  // -------------------------------
  logic sys_clk = 1'b0; // 25 MHz
  logic rst_n = 1'b0; // Held 16 cycles
  logic sync_clr = 1'b0; // Clears filter, restarts settling
  logic [15:0] vin_code = 16'h8000; // Input level
  logic [15:0] offset_trim = 16'h8000; // No correction
  logic [15:0] ovl_limit = 16'hc000; // Overload window
  logic [15:0] gain_trim = 16'h8000; // Unity gain in 1.15
  logic [15:0] word_data;
  logic word_valid;
  logic overload;
  int errors = 0;
  int n_compared = 0;
  int seed = int'(32'hc4041531); // Fixed for repeatable runs
  logic [15:0] codes [5] = '{16'h8000, 16'hd000, 16'h3000, 16'hffff, 16'h0000};
  always #20 sys_clk = ~sys_clk;
  sdm_link_if link ();
  sdm_modulator sdm_modulator_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
    .vin_code(vin_code), .link(link));
  sinc3_decimator sinc3_decimator_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
    .link(link), .sync_clr(sync_clr), .offset_trim(offset_trim), .gain_trim(gain_trim),
    .ovl_limit(ovl_limit), .word_data(word_data), .word_valid(word_valid),
    .overload(overload));
  sdm_link_sva sdm_link_sva_inst (.sys_clk(sys_clk), .rst_n(rst_n), .mclk(link.mclk),
    .mdat(link.mdat));
  // -------------------------------
  // Helpers
  // -------------------------------
  // Tolerance covers the density coder's one-bit jitter per window
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp,
    input int tol);
    int d;
    d = int'(seen) - int'(exp);
    n_compared++;
    if ($isunknown(seen) || d > tol || -d > tol)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Offset then 1.15 gain, each saturating at the code range ends
  function automatic logic [15:0] exp_word(logic [15:0] c, logic [15:0] off,
    logic [15:0] g);
    longint v;
    v = longint'(c) - longint'(off) + 32768;
    if (v < 0)
      v = 0;
    if (v > 65535)
      v = 65535;
    v = (v * longint'(g)) >>> 15;
    if (v > 65535)
      v = 65535;
    return 16'(v);
  endfunction
  function automatic logic [15:0] exp_ovl(logic [15:0] w);
    return {15'h0000, (w > 16'hc000) || (w < 16'h3fff)};
  endfunction
  // Bounded wait for the next word, counted in sys cycles
  task wait_word(output int cyc);
    cyc = 0;
    do
    begin
      @(negedge sys_clk);
      cyc++;
    end
    while (word_valid !== 1'b1 && cyc < 5000);
  endtask
  // Clear, skip settling, then judge the second steady word
  task run_case(input logic [15:0] code, input logic [15:0] off, input logic [15:0] g);
    int c1;
    int c2;
    @(posedge sys_clk);
    vin_code <= code;
    offset_trim <= off;
    gain_trim <= g;
    sync_clr <= 1'b1;
    repeat (8) @(posedge sys_clk);
    sync_clr <= 1'b0;
    wait_word(c1);
    check("settle gap", 16'(c1 > 2048), 16'h0001, 0);
    @(negedge sys_clk);
    check("valid width", 16'(word_valid), 16'h0000, 0);
    wait_word(c2);
    check("word spacing", 16'(c2), 16'(2 * MCLK_HALF * DEC_RATIO - 1), 0);
    check("word", word_data, exp_word(code, off, g), 8);
    check("overload", 16'(overload), exp_ovl(exp_word(code, off, g)), 0);
    $display("test level %h offset %h done", code, off);
  endtask
  // -------------------------------
  // Main sequence and watchdog
  // -------------------------------
  initial
  begin
    repeat (16) @(posedge sys_clk);
    check("reset word", word_data, 16'h8000, 0);
    check("reset valid", 16'(word_valid), 16'h0000, 0);
    rst_n <= 1'b1;
    // Mid, +200 mV, -200 mV, full scale both ways
    foreach (codes[i])
      run_case(codes[i], 16'h8000, 16'h8000);
    run_case(16'h8000, 16'h8100, 16'h8000);
    // Trim below mid-scale must saturate high, not wrap
    run_case(16'hf000, 16'h7000, 16'h8000);
    // Half gain scales the word down
    run_case(16'hc000, 16'h8000, 16'h4000);
    repeat (3)
      run_case(16'h4100 + (16'($random(seed)) & 16'h7dff), 16'h8000, 16'h8000);
    end_of_test;
  end
  initial
  begin
    #(40 * 80000);
    errors++;
    end_of_test;
  end
endmodule // test_bitstream_sinc3_decimator
`default_nettype wire
